// [dsg_pkg.sv]
// Shared constants and types for the deep-sleep clock gate block.
// Assumes one 50 MHz system clock and an APB master on the same clock.
// Contract
// - Gate register decoded at byte 0x120
// - Reset value is 0x00000040
// - Set bit clocks unit, clear stops it
// - Access to unclocked unit returns bus fault
// - Enables chosen by run, sleep, deep mode
// - Sleep/deep registers need auto-gate select set
// - Bit 20 gates pulse-width modulator, reset low
// - Bit 16 gates converter 0, reset low
// - Bit 6 gates hibernation, reset high
// - Bit 3 gates watchdog, reset low
// - Reserved bits read-only, read zero
package dsg_pkg;

  localparam int          ADDR_W         = 12;
  localparam int          DATA_W         = 32;
  localparam int          UNIT_N         = 4;
  localparam int          IRQ_W          = 2;

  localparam logic [11:0] OFS_RUN_GATE   = 12'h100;
  localparam logic [11:0] OFS_SLEEP_GATE = 12'h110;
  localparam logic [11:0] OFS_DEEP_GATE  = 12'h120;
  localparam logic [11:0] OFS_MODE_CTRL  = 12'h140;
  localparam logic [11:0] OFS_IRQ_STAT   = 12'h144;
  localparam logic [11:0] OFS_IRQ_MASK   = 12'h148;

  localparam logic [31:0] GATE_RESET     = 32'h0000_0040;
  localparam logic [31:0] GATE_WR_MASK   = 32'h0011_0048;
  localparam logic [31:0] MODE_RESET     = 32'h0000_0000;

  localparam int          BIT_PWM        = 20;
  localparam int          BIT_ADC0       = 16;
  localparam int          BIT_HIBER      = 6;
  localparam int          BIT_WDOG       = 3;
  localparam int          BIT_AUTO_GATE  = 0;

  localparam int          IRQ_FAULT      = 0;
  localparam int          IRQ_CHANGE     = 1;

  localparam logic [1:0]  UNIT_WDOG      = 2'h0;
  localparam logic [1:0]  UNIT_HIBER     = 2'h1;
  localparam logic [1:0]  UNIT_ADC0      = 2'h2;
  localparam logic [1:0]  UNIT_PWM       = 2'h3;

  typedef enum logic [1:0] {
    DSG_PM_RUN   = 2'h0,
    DSG_PM_SLEEP = 2'h1,
    DSG_PM_DEEP  = 2'h3
  } dsg_pmode_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } dsg_apb_req_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] unit;
  } dsg_periph_req_t;

endpackage

// [dsg_clk_en_cell.sv]
// One glitch-free clock enable stage for a gated unit.
// Assumes the unit clocks on i_sys_clk qualified by o_clk_en.
`timescale 1ns/1ps
module dsg_clk_en_cell (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_b,
  input  wire logic i_en_req,
  input  wire logic i_en_rst,
  output logic      o_clk_en
);

  // Enable only moves on an edge, so the unit sees whole cycles only
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_clk_en <= 1'b0;
    end else begin
      o_clk_en <= i_en_req;
    end
  end

  // Reset level pin is unused; the enable always resets low
  logic unused_en_rst;
  assign unused_en_rst = i_en_rst;

endmodule

// [dsg_irq_bank.sv]
// Sticky event status with mask and one level interrupt.
// Assumes set pulses and clear masks come from the same clock.
`timescale 1ns/1ps
module dsg_irq_bank #(
  parameter int W = 2
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_set,
  input  wire logic [W-1:0] i_clr,
  input  wire logic         i_mask_we,
  input  wire logic [W-1:0] i_mask_wdata,
  output logic      [W-1:0] o_status,
  output logic      [W-1:0] o_mask,
  output logic              o_irq
);

  logic [W-1:0] status_nxt;

  // Set beats clear so no event is lost on a read
  assign status_nxt = (o_status & ~i_clr) | i_set;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_status <= '0;
      o_mask   <= '0;
      o_irq    <= 1'b0;
    end else begin
      o_status <= status_nxt;
      if (i_mask_we) begin
        o_mask <= i_mask_wdata;
      end
      o_irq <= |(status_nxt & (i_mask_we ? i_mask_wdata : o_mask));
    end
  end

endmodule

// [dsg_deep_gate.sv]
// Deep-sleep clock gate register block with APB slave and fault check.
// Assumes APB master, power mode and peripheral probes on i_sys_clk.
`timescale 1ns/1ps
module dsg_deep_gate (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_rst_b,
  input  wire dsg_pkg::dsg_apb_req_t    i_apb,
  input  wire dsg_pkg::dsg_pmode_t      i_power_mode,
  input  wire dsg_pkg::dsg_periph_req_t i_periph_req,
  output logic                          o_pready,
  output logic [31:0]                   o_prdata,
  output logic                          o_pslverr,
  output logic [3:0]                    o_unit_clk_en,
  output logic                          o_periph_fault,
  output logic                          o_irq
);
  import dsg_pkg::*;

  logic [31:0]      run_gate_reg0_r;
  logic [31:0]      sleep_gate_reg0_r;
  logic [31:0]      deep_sleep_gate_reg0_r;
  logic [31:0]      mode_ctrl_r;
  logic [31:0]      rd_nxt;
  logic             err_nxt;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [IRQ_W-1:0] stat_cap_r;

  // Bus phase decode
  wire setup_ph  = i_apb.psel & ~i_apb.penable;
  wire done_ph   = i_apb.psel & i_apb.penable & o_pready;
  wire wr_done   = done_ph & i_apb.pwrite;
  wire rd_done   = done_ph & ~i_apb.pwrite;
  wire [11:0] ad = i_apb.paddr;

  wire hit_run   = (ad == OFS_RUN_GATE);
  wire hit_sleep = (ad == OFS_SLEEP_GATE);
  wire hit_deep  = (ad == OFS_DEEP_GATE);
  wire hit_mode  = (ad == OFS_MODE_CTRL);
  wire hit_stat  = (ad == OFS_IRQ_STAT);
  wire hit_mask  = (ad == OFS_IRQ_MASK);
  wire hit_any   = hit_run | hit_sleep | hit_deep | hit_mode | hit_stat | hit_mask;

  wire we_run    = wr_done & hit_run;
  wire we_sleep  = wr_done & hit_sleep;
  wire we_deep   = wr_done & hit_deep;
  wire we_mode   = wr_done & hit_mode;
  wire we_mask   = wr_done & hit_mask;
  wire re_stat   = rd_done & hit_stat;

  // Only gate bits are writable, the rest stays zero
  wire [31:0] gate_wdata = i_apb.pwdata & GATE_WR_MASK;

  always_comb begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    if (hit_run) begin
      rd_nxt = run_gate_reg0_r;
    end else if (hit_sleep) begin
      rd_nxt = sleep_gate_reg0_r;
    end else if (hit_deep) begin
      rd_nxt = deep_sleep_gate_reg0_r & GATE_WR_MASK;
    end else if (hit_mode) begin
      rd_nxt = mode_ctrl_r;
    end else if (hit_stat) begin
      rd_nxt = {{(32-IRQ_W){1'b0}}, irq_status};
    end else if (hit_mask) begin
      rd_nxt = {{(32-IRQ_W){1'b0}}, irq_mask};
    end else begin
      err_nxt = 1'b1;
    end
  end

  // One access cycle, no wait states; data latched at setup
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_pready   <= 1'b0;
      o_prdata   <= 32'h0000_0000;
      o_pslverr  <= 1'b0;
      stat_cap_r <= '0;
    end else begin
      o_pready <= setup_ph;
      if (setup_ph) begin
        o_prdata   <= i_apb.pwrite ? 32'h0000_0000 : rd_nxt;
        o_pslverr  <= err_nxt;
        stat_cap_r <= irq_status;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      run_gate_reg0_r        <= GATE_RESET;
      sleep_gate_reg0_r      <= GATE_RESET;
      deep_sleep_gate_reg0_r <= GATE_RESET;
      mode_ctrl_r            <= MODE_RESET;
    end else begin
      if (we_run) begin
        run_gate_reg0_r <= gate_wdata;
      end
      if (we_sleep) begin
        sleep_gate_reg0_r <= gate_wdata;
      end
      if (we_deep) begin
        deep_sleep_gate_reg0_r <= gate_wdata;
      end
      if (we_mode) begin
        mode_ctrl_r <= i_apb.pwdata & 32'h0000_0001;
      end
    end
  end

  // Mode selection of the governing gate register
  wire        auto_clock_gate_select = mode_ctrl_r[BIT_AUTO_GATE];
  wire        in_sleep = (i_power_mode == DSG_PM_SLEEP);
  wire        in_deep  = (i_power_mode == DSG_PM_DEEP);
  wire [31:0] sel_gate =
    (auto_clock_gate_select & in_deep)  ? deep_sleep_gate_reg0_r :
    (auto_clock_gate_select & in_sleep) ? sleep_gate_reg0_r :
    run_gate_reg0_r;

  wire pwm_gate_enable         = sel_gate[BIT_PWM];
  wire adc0_gate_enable        = sel_gate[BIT_ADC0];
  wire hibernation_gate_enable = sel_gate[BIT_HIBER];
  wire watchdog_gate_enable    = sel_gate[BIT_WDOG];

  wire [3:0] unit_en_req = {pwm_gate_enable, adc0_gate_enable,
                            hibernation_gate_enable, watchdog_gate_enable};
  wire [3:0] unit_en_rst = {GATE_RESET[BIT_PWM], GATE_RESET[BIT_ADC0],
                            GATE_RESET[BIT_HIBER], GATE_RESET[BIT_WDOG]};

  genvar g;
  generate
    for (g = 0; g < UNIT_N; g++) begin : g_cell
      dsg_clk_en_cell u_cell (
        .i_sys_clk (i_sys_clk),
        .i_rst_b   (i_rst_b),
        .i_en_req  (unit_en_req[g]),
        .i_en_rst  (unit_en_rst[g]),
        .o_clk_en  (o_unit_clk_en[g])
      );
    end
  endgenerate

  // Faults judged against the enable the unit is really running on
  wire fault_now = i_periph_req.valid & ~o_unit_clk_en[i_periph_req.unit];

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_periph_fault <= 1'b0;
    end else begin
      o_periph_fault <= fault_now;
    end
  end

  assign irq_set[IRQ_FAULT]  = fault_now;
  assign irq_set[IRQ_CHANGE] = |(unit_en_req ^ o_unit_clk_en);
  // Clear only what the read returned; later events stay pending
  assign irq_clr             = re_stat ? stat_cap_r : '0;

  dsg_irq_bank #(
    .W (IRQ_W)
  ) u_irq (
    .i_sys_clk    (i_sys_clk),
    .i_rst_b      (i_rst_b),
    .i_set        (irq_set),
    .i_clr        (irq_clr),
    .i_mask_we    (we_mask),
    .i_mask_wdata (i_apb.pwdata[IRQ_W-1:0]),
    .o_status     (irq_status),
    .o_mask       (irq_mask),
    .o_irq        (o_irq)
  );

  // Checks

  a_reset_value: assert property (@(posedge i_sys_clk)
    $rose(i_rst_b) |-> deep_sleep_gate_reg0_r == 32'h0000_0040 &&
                       o_unit_clk_en == 4'h0)
    else $error("gate register reset value wrong");

  a_deep_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (wr_done && ad == 12'h120) |=>
      deep_sleep_gate_reg0_r == ($past(i_apb.pwdata) & 32'h0011_0048))
    else $error("write to gate register not stored");

  a_reserved_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (rd_done && hit_deep) |-> (o_prdata & 32'hffee_ffb7) == 32'h0)
    else $error("reserved bit read as one");

  a_fault_gated: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_periph_req.valid && !o_unit_clk_en[i_periph_req.unit]) |=> o_periph_fault)
    else $error("gated unit access without fault");

  a_no_fault_on: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_periph_req.valid && o_unit_clk_en[i_periph_req.unit]) |=> !o_periph_fault)
    else $error("fault on clocked unit");

  a_deep_select: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (mode_ctrl_r[0] && i_power_mode == DSG_PM_DEEP) ##1 $stable(unit_en_req) |->
      o_unit_clk_en == $past({deep_sleep_gate_reg0_r[20], deep_sleep_gate_reg0_r[16],
                              deep_sleep_gate_reg0_r[6], deep_sleep_gate_reg0_r[3]}))
    else $error("deep mode not using deep gate register");

  a_acg_off_run: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    !mode_ctrl_r[0] |-> unit_en_req == {run_gate_reg0_r[20], run_gate_reg0_r[16],
                                        run_gate_reg0_r[6], run_gate_reg0_r[3]})
    else $error("sleep registers used without auto gate");

  a_bit_map: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    sel_gate[20] == unit_en_req[3] && sel_gate[16] == unit_en_req[2] &&
    sel_gate[6] == unit_en_req[1] && sel_gate[3] == unit_en_req[0])
    else $error("gate bit mapped to wrong unit");

  a_en_latency: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    $changed(o_unit_clk_en) |-> o_unit_clk_en == $past(unit_en_req) &&
                                $past(unit_en_req) != $past(o_unit_clk_en))
    else $error("clock enable moved off the edge");

  a_hib_reset: assert property (@(posedge i_sys_clk)
    $rose(i_rst_b) ##1 (!mode_ctrl_r[0]) |-> o_unit_clk_en == 4'h2)
    else $error("hibernation enable not set after reset");

  a_irq_level: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    ##1 (o_irq == |(irq_status & irq_mask)))
    else $error("interrupt level disagrees with status");

  c_deep_write: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    wr_done && hit_deep);
  c_fault: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    o_periph_fault && in_deep);
  c_stat_read: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    re_stat && stat_cap_r != '0);
  c_unmapped: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    done_ph && o_pslverr);

endmodule

// [tb.sv]
// Self-checking bench for the deep-sleep clock gate register block.
// Assumes the design files and dsg_pkg are compiled first; APB on i_sys_clk.
`timescale 1ns/1ps
module tb;
  import dsg_pkg::*;

  logic            sys_clk;
  logic            rst_b;
  dsg_apb_req_t    apb;
  dsg_pmode_t      pmode;
  dsg_periph_req_t preq;
  logic            pready;
  logic [31:0]     prdata;
  logic            pslverr;
  logic [3:0]      clk_en;
  logic            fault;
  logic            irq;
  int              bad_count;
  int              cmp_count;
  int              seed;
  logic [31:0]     m_gate [3];
  logic            m_acg;
  logic [11:0]     gofs [3];
  logic [31:0]     rd;
  logic            err;
  logic [31:0]     d;
  dsg_pmode_t      pm_tab [3];

  dsg_deep_gate i_dut (
    .i_sys_clk      (sys_clk),
    .i_rst_b        (rst_b),
    .i_apb          (apb),
    .i_power_mode   (pmode),
    .i_periph_req   (preq),
    .o_pready       (pready),
    .o_prdata       (prdata),
    .o_pslverr      (pslverr),
    .o_unit_clk_en  (clk_en),
    .o_periph_fault (fault),
    .o_irq          (irq)
  );

  always #10 sys_clk = ~sys_clk;

  task automatic conclude();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; holds the request until pready is sampled
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    apb.psel    <= 1'b1;
    apb.penable <= 1'b0;
    apb.pwrite  <= w;
    apb.paddr   <= a;
    apb.pwdata  <= wd;
    @(posedge sys_clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    apb.psel    <= 1'b0;
    apb.penable <= 1'b0;
    // Idle edge so a following setup never reassigns psel in this step
    @(posedge sys_clk);
  endtask

  // Which gate register governs follows power mode only with auto-gating set
  function automatic logic [3:0] exp_en();
    logic [31:0] r;
    r = m_gate[0];
    if (m_acg && pmode == DSG_PM_SLEEP) r = m_gate[1];
    if (m_acg && pmode == DSG_PM_DEEP) r = m_gate[2];
    return {r[20], r[16], r[6], r[3]};
  endfunction

  task automatic probe(input logic [1:0] u);
    logic [3:0] e;
    preq <= '{valid: 1'b1, unit: u};
    @(posedge sys_clk);
    preq <= '{valid: 1'b0, unit: 2'h0};
    @(posedge sys_clk);
    e = exp_en();
    chk({31'h0, fault}, {31'h0, ~e[u]});
  endtask

  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    conclude();
  end

  initial begin
    sys_clk = 1'b0;
    rst_b   = 1'b0;
    apb     = '0;
    pmode   = DSG_PM_RUN;
    preq    = '0;
    bad_count = 0;
    cmp_count = 0;
    seed    = 44;
    m_acg   = 1'b0;
    gofs    = '{OFS_RUN_GATE, OFS_SLEEP_GATE, 12'h120};
    pm_tab  = '{DSG_PM_RUN, DSG_PM_SLEEP, DSG_PM_DEEP};
    for (int i = 0; i < 3; i++) m_gate[i] = 32'h0000_0040;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    @(posedge sys_clk);
    chk({28'h0, clk_en}, {28'h0, exp_en()});
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, gofs[i], 32'h0);
      chk(rd, 32'h0000_0040);
    end
    bus(1'b0, OFS_MODE_CTRL, 32'h0);
    chk(rd, 32'h0);
    // Unmapped neighbour: refused, write must not leak into the gate
    bus(1'b1, 12'h124, 32'hffff_ffff);
    chk({31'h0, err}, 32'h1);
    bus(1'b0, 12'h124, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    bus(1'b0, 12'h120, 32'h0);
    chk({31'h0, err}, 32'h0);
    chk(rd, m_gate[2]);
    for (int k = 0; k < 9; k++) begin
      d = (k < 3) ? 32'hffff_ffff : $random(seed);
      bus(1'b1, gofs[k % 3], d);
      m_gate[k % 3] = d & 32'h0011_0048;
      bus(1'b0, gofs[k % 3], 32'h0);
      chk(rd, m_gate[k % 3]);
    end
    for (int a = 0; a < 2; a++) begin
      for (int p = 0; p < 3; p++) begin
        m_acg = a[0];
        bus(1'b1, OFS_MODE_CTRL, {31'h0, m_acg});
        pmode <= pm_tab[p];
        repeat (3) @(posedge sys_clk);
        chk({28'h0, clk_en}, {28'h0, exp_en()});
        for (int u = 0; u < 4; u++) probe(u[1:0]);
      end
    end
    d = $random(seed);
    bus(1'b1, 12'h120, d);
    m_gate[2] = d & 32'h0011_0048;
    repeat (2) @(posedge sys_clk);
    chk({28'h0, clk_en}, {28'h0, exp_en()});
    for (int u = 0; u < 4; u++) probe(u[1:0]);
    // Interrupt: gate everything, unmask fault event only
    bus(1'b1, 12'h120, 32'h0);
    m_gate[2] = 32'h0;
    bus(1'b1, OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge sys_clk);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    probe(UNIT_WDOG);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk({31'h0, rd[0]}, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, OFS_IRQ_MASK, 32'h0);
    probe(UNIT_PWM);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk({31'h0, rd[0]}, 32'h1);
    conclude();
  end
endmodule
